// [include/tap_pkg.sv]
package tap_pkg;

  // ------------------------------------------------------------
  // instruction codes and identification
  // ------------------------------------------------------------
  localparam logic [3:0] IR_IDCODE = 4'h2;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_RESET_VALUE = 4'h2;
  localparam logic [3:0] IR_CAPTURE_VALUE = 4'h1;
  localparam logic [31:0] ID_VALUE = 32'h0000_0001; // arbitrary value
  localparam logic CTRL_SELECT_RESET = 1'b1;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    TEST_RESET, RUN_IDLE, SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
    UPDATE_DR, SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
  } tap_state_t;

  // pins driven by the debugger
  typedef struct packed {
    logic clk;
    logic mode_sel;
    logic data_in;
    logic reset_n;
    logic ctrl_select;
  } link_in_t;

  // serial output pin with its enable
  typedef struct packed {
    logic data_out;
    logic data_out_oe;
  } link_out_t;

  // whole state of the front end
  typedef struct packed {
    link_in_t sync1;
    link_in_t sync2;
    logic clk_prev;
    logic trst_prev;
    tap_state_t tap;
    logic [3:0] ir_shift;
    logic [3:0] ir;
    logic [31:0] dr;
    link_out_t out;
    logic ctrl_latched;
  } fe_state_t;

endpackage

// [logic/test_access_port_front_end.sv]
`timescale 1ns/1ps
`default_nettype none

module test_access_port_front_end (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire tap_pkg::link_in_t pins_in,
  input wire logic single_wire_sel,
  input wire logic single_wire_out,
  input wire logic single_wire_oe,
  output var tap_pkg::link_out_t pins_out,
  output logic shared_pin_out,
  output logic shared_pin_oe,
  output logic mfg_test_select,
  output var tap_pkg::tap_state_t tap_state,
  output logic [3:0] instruction
);

  // ------------------------------------------------------------
  // controller step function
  // ------------------------------------------------------------
  function automatic tap_pkg::tap_state_t next_tap(input tap_pkg::tap_state_t st,
                                                   input logic tms);
    case (st)
      tap_pkg::TEST_RESET: next_tap = tms ? tap_pkg::TEST_RESET : tap_pkg::RUN_IDLE;
      tap_pkg::RUN_IDLE: next_tap = tms ? tap_pkg::SELECT_DR : tap_pkg::RUN_IDLE;
      tap_pkg::SELECT_DR: next_tap = tms ? tap_pkg::SELECT_IR : tap_pkg::CAPTURE_DR;
      tap_pkg::CAPTURE_DR: next_tap = tms ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
      tap_pkg::SHIFT_DR: next_tap = tms ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
      tap_pkg::EXIT1_DR: next_tap = tms ? tap_pkg::UPDATE_DR : tap_pkg::PAUSE_DR;
      tap_pkg::PAUSE_DR: next_tap = tms ? tap_pkg::EXIT2_DR : tap_pkg::PAUSE_DR;
      tap_pkg::EXIT2_DR: next_tap = tms ? tap_pkg::UPDATE_DR : tap_pkg::SHIFT_DR;
      tap_pkg::UPDATE_DR: next_tap = tms ? tap_pkg::SELECT_DR : tap_pkg::RUN_IDLE;
      tap_pkg::SELECT_IR: next_tap = tms ? tap_pkg::TEST_RESET : tap_pkg::CAPTURE_IR;
      tap_pkg::CAPTURE_IR: next_tap = tms ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
      tap_pkg::SHIFT_IR: next_tap = tms ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
      tap_pkg::EXIT1_IR: next_tap = tms ? tap_pkg::UPDATE_IR : tap_pkg::PAUSE_IR;
      tap_pkg::PAUSE_IR: next_tap = tms ? tap_pkg::EXIT2_IR : tap_pkg::PAUSE_IR;
      tap_pkg::EXIT2_IR: next_tap = tms ? tap_pkg::UPDATE_IR : tap_pkg::SHIFT_IR;
      default: next_tap = tms ? tap_pkg::SELECT_DR : tap_pkg::RUN_IDLE;
    endcase
  endfunction

  // ------------------------------------------------------------
  // state, reset and edge detection
  // ------------------------------------------------------------
  tap_pkg::fe_state_t s;
  tap_pkg::fe_state_t next_s;
  logic rst_n;
  logic tck_rise;
  logic tck_fall;
  logic trst_rise;

  // either reset clears the controller without waiting for any clock
  assign rst_n = arst_n & pins_in.reset_n;
  // edges of the resynchronised test clock and test reset
  assign tck_rise = s.sync2.clk & ~s.clk_prev;
  assign tck_fall = ~s.sync2.clk & s.clk_prev;
  assign trst_rise = s.sync2.reset_n & ~s.trst_prev;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.sync1 = pins_in;
    next_s.sync2 = s.sync1;
    next_s.clk_prev = s.sync2.clk;
    next_s.trst_prev = s.sync2.reset_n;
    // select level caught once test reset is released
    if (trst_rise) begin
      next_s.ctrl_latched = s.sync2.ctrl_select;
    end
    if (tck_rise) begin
      next_s.tap = next_tap(s.tap, s.sync2.mode_sel);
      case (s.tap)
        tap_pkg::TEST_RESET: begin
          next_s.ir = tap_pkg::IR_RESET_VALUE;
        end
        tap_pkg::CAPTURE_DR: begin
          next_s.dr = (s.ir == tap_pkg::IR_IDCODE) ? tap_pkg::ID_VALUE : 32'h0000_0000;
        end
        tap_pkg::SHIFT_DR: begin
          if (s.ir == tap_pkg::IR_IDCODE) begin
            next_s.dr = {s.sync2.data_in, s.dr[31:1]};
          end else begin
            next_s.dr = {31'h0000_0000, s.sync2.data_in};
          end
        end
        tap_pkg::CAPTURE_IR: begin
          next_s.ir_shift = tap_pkg::IR_CAPTURE_VALUE;
        end
        tap_pkg::SHIFT_IR: begin
          next_s.ir_shift = {s.sync2.data_in, s.ir_shift[3:1]};
        end
        tap_pkg::UPDATE_IR: begin
          next_s.ir = s.ir_shift;
        end
        default: begin
          next_s.ir = s.ir;
        end
      endcase
    end
    // output moves only on a falling test clock edge
    if (tck_fall) begin
      next_s.out.data_out = (s.tap == tap_pkg::SHIFT_IR) ? s.ir_shift[0] : s.dr[0];
      next_s.out.data_out_oe = (s.tap == tap_pkg::SHIFT_IR) || (s.tap == tap_pkg::SHIFT_DR);
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // synchronisers clear too, so no false test clock edge follows reset
      s <= '0;
      s.tap <= tap_pkg::TEST_RESET;
      s.ir <= tap_pkg::IR_RESET_VALUE;
      s.ctrl_latched <= tap_pkg::CTRL_SELECT_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // shared pin carries the single-wire function or the return clock, never both
  assign shared_pin_out = single_wire_sel ? single_wire_out : s.clk_prev;
  assign shared_pin_oe = single_wire_sel ? single_wire_oe : 1'b1;
  assign pins_out = s.out;
  assign mfg_test_select = ~s.ctrl_latched;
  assign tap_state = s.tap;
  assign instruction = s.ir;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // all checks run on the system clock; the two test reset checks rest only while arst_n is low, the rest while either reset is low
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_data_in_capture: assert property (
    tck_rise && s.tap == tap_pkg::SHIFT_DR && s.ir != tap_pkg::IR_IDCODE
    |=> s.dr[0] == $past(s.sync2.data_in))
    else $error("serial input not captured on rising test clock");

  chk_mode_step: assert property (
    tck_rise |=> s.tap == next_tap($past(s.tap), $past(s.sync2.mode_sel)))
    else $error("controller did not step on rising test clock");

  chk_mode_hold: assert property (
    !tck_rise |=> $stable(s.tap))
    else $error("controller moved without a rising test clock");

  chk_out_fall_only: assert property (
    !tck_fall |=> $stable(pins_out.data_out) && $stable(pins_out.data_out_oe))
    else $error("serial output changed away from a falling edge");

  chk_trst_immediate: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    !pins_in.reset_n |-> s.tap == tap_pkg::TEST_RESET)
    else $error("test reset did not hold the controller in reset");

  chk_select_latch: assert property (
    trst_rise |=> s.ctrl_latched == $past(s.sync2.ctrl_select) ##1 $stable(s.ctrl_latched))
    else $error("controller select not latched at test reset release");

  // shared pin ownership and return clock
  chk_pin_owner: assert property (
    single_wire_sel |-> shared_pin_out == single_wire_out && shared_pin_oe == single_wire_oe)
    else $error("shared pin not handed to the single-wire function");

  chk_return_clock: assert property (
    !single_wire_sel && $past(rst_n, 3)
    |-> shared_pin_oe && shared_pin_out == $past(pins_in.clk, 3))
    else $error("return clock does not follow the test clock");

  // test reset also restores the instruction and parks the serial output
  chk_trst_instr: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    !pins_in.reset_n |-> s.ir == tap_pkg::IR_RESET_VALUE && !pins_out.data_out_oe)
    else $error("test reset did not restore instruction and output enable");

  // instruction bits enter at the top of the shift register on a rise
  chk_ir_shift_in: assert property (
    tck_rise && s.tap == tap_pkg::SHIFT_IR |=> s.ir_shift[3] == $past(s.sync2.data_in))
    else $error("instruction bit not captured on rising test clock");

  // the shifted instruction takes effect when the update state is left
  chk_ir_update: assert property (
    tck_rise && s.tap == tap_pkg::UPDATE_IR |=> s.ir == $past(s.ir_shift))
    else $error("instruction not updated on leaving the update state");

  // a falling edge in data shift presents the low bit with the driver on
  chk_out_source: assert property (
    tck_fall && s.tap == tap_pkg::SHIFT_DR
    |=> pins_out.data_out == $past(s.dr[0]) && pins_out.data_out_oe)
    else $error("serial output does not show the data register low bit");

  // the select latch only moves at a test reset release
  chk_select_hold: assert property (
    !trst_rise |=> $stable(s.ctrl_latched))
    else $error("controller select changed away from test reset release");

  cov_shift_dr: cover property (tck_rise && s.tap == tap_pkg::SHIFT_DR ##[1:40] tck_fall);
  cov_ir_update: cover property (tck_rise && s.tap == tap_pkg::UPDATE_IR);
  cov_mfg_select: cover property (trst_rise && !s.sync2.ctrl_select);
  // bypass path and a return clock edge seen on the shared pin
  cov_bypass_shift: cover property (tck_rise && s.tap == tap_pkg::SHIFT_DR
    && s.ir == tap_pkg::IR_BYPASS);
  cov_return_clock: cover property (!single_wire_sel && tck_rise);

endmodule

`default_nettype wire

// [sim/debugger_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// debugger driving the test port pins
// ------------------------------------------------------------
module debugger_model (
  output var tap_pkg::link_in_t pins,
  input wire logic tdo
);
  // idle pins, test clock standing low, select high for normal use
  initial begin
    pins = '{clk: 1'b0, mode_sel: 1'b1, data_in: 1'b0, reset_n: 1'b1, ctrl_select: 1'b1};
  end

  // one clock period: inputs set while low, output taken just before the rise
  task automatic bit_cycle(input logic tms, input logic tdi, output logic seen);
    pins.mode_sel = tms;
    pins.data_in = tdi;
    #100;
    seen = tdo;
    pins.clk = 1'b1;
    #100;
    pins.clk = 1'b0;
  endtask

  // test reset and controller select levels
  task automatic set_reset(input logic rst_n, input logic sel);
    pins.reset_n = rst_n;
    pins.ctrl_select = sel;
  endtask
endmodule

`default_nettype wire

// [sim/test_test_access_port_front_end.sv]
`timescale 1ns/1ps
`default_nettype none

module test_test_access_port_front_end;
  logic ref_clk;
  logic arst_n;
  logic single_wire_sel;
  logic single_wire_out;
  logic single_wire_oe;
  tap_pkg::link_in_t pins_in;
  tap_pkg::link_out_t pins_out;
  logic shared_pin_out;
  logic shared_pin_oe;
  logic mfg_test_select;
  tap_pkg::tap_state_t tap_state;
  logic [3:0] instruction;
  logic [63:0] seen_bits;
  logic tdo_bit;
  int num_errors;
  int checks_done;

  test_access_port_front_end dut (.ref_clk(ref_clk), .arst_n(arst_n), .pins_in(pins_in),
    .single_wire_sel(single_wire_sel), .single_wire_out(single_wire_out),
    .single_wire_oe(single_wire_oe), .pins_out(pins_out), .shared_pin_out(shared_pin_out),
    .shared_pin_oe(shared_pin_oe), .mfg_test_select(mfg_test_select),
    .tap_state(tap_state), .instruction(instruction));

  debugger_model dbg (.pins(pins_in), .tdo(pins_out.data_out));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // walk the controller into the data shift state
  task automatic go_shift_dr();
    logic [3:0] path;
    path = 4'h2;
    for (int i = 0; i < 4; i++) begin
      dbg.bit_cycle(path[i], 1'b0, tdo_bit);
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic read_id();
    logic [31:0] pattern;
    pattern = 32'hA5C3_0F1E;
    go_shift_dr();
    check("state", 32'(tap_state), 32'(tap_pkg::SHIFT_DR));
    for (int i = 0; i < 64; i++) begin
      dbg.bit_cycle(i == 63, (i < 32) ? pattern[i] : 1'b0, seen_bits[i]);
    end
    check("id", seen_bits[31:0], tap_pkg::ID_VALUE);
    check("echo", seen_bits[63:32], pattern);
    dbg.bit_cycle(1'b1, 1'b0, tdo_bit);
    dbg.bit_cycle(1'b0, 1'b0, tdo_bit);
    #100;
    check("state", 32'(tap_state), 32'(tap_pkg::RUN_IDLE));
    check("oe", 32'(pins_out.data_out_oe), 32'h0000_0000);
  endtask

  task automatic reset_async();
    go_shift_dr();
    #100;
    check("oe", 32'(pins_out.data_out_oe), 32'h0000_0001);
    dbg.set_reset(1'b0, 1'b0);
    #1;
    check("state", 32'(tap_state), 32'(tap_pkg::TEST_RESET));
    check("oe", 32'(pins_out.data_out_oe), 32'h0000_0000);
    #99;
    dbg.set_reset(1'b1, 1'b0);
    #200;
    check("mfg", 32'(mfg_test_select), 32'h0000_0001);
    dbg.set_reset(1'b1, 1'b1);
    #200;
    check("mfg", 32'(mfg_test_select), 32'h0000_0001);
    dbg.set_reset(1'b0, 1'b1);
    #100;
    dbg.set_reset(1'b1, 1'b1);
    #200;
    check("mfg", 32'(mfg_test_select), 32'h0000_0000);
  endtask

  task automatic shared_pin();
    single_wire_sel = 1'b0;
    fork
      dbg.bit_cycle(1'b1, 1'b0, tdo_bit);
      begin
        #90;
        check("ret_clk", 32'(shared_pin_out), 32'h0000_0000);
        #100;
        check("ret_clk", 32'(shared_pin_out), 32'h0000_0001);
        check("ret_oe", 32'(shared_pin_oe), 32'h0000_0001);
      end
    join
    #100;
    check("ret_clk", 32'(shared_pin_out), 32'h0000_0000);
    single_wire_sel = 1'b1;
    single_wire_out = 1'b1;
    #25;
    check("sw_out", {30'h0, shared_pin_out, shared_pin_oe}, 32'h0000_0002);
    single_wire_out = 1'b0;
    single_wire_oe = 1'b1;
    #25;
    check("sw_out", {30'h0, shared_pin_out, shared_pin_oe}, 32'h0000_0001);
  endtask

  // load the bypass instruction, then shift through the one-bit path
  task automatic bypass_ir();
    logic [4:0] path;
    logic [3:0] seen4;
    logic [3:0] pat;
    path = 5'h06;
    pat = 4'hB;
    for (int i = 0; i < 5; i++) begin
      dbg.bit_cycle(path[i], 1'b0, tdo_bit);
    end
    for (int i = 0; i < 4; i++) begin
      dbg.bit_cycle(i == 3, tap_pkg::IR_BYPASS[i], seen4[i]);
    end
    check("ir_capture", 32'(seen4), 32'(tap_pkg::IR_CAPTURE_VALUE));
    dbg.bit_cycle(1'b1, 1'b0, tdo_bit);
    dbg.bit_cycle(1'b0, 1'b0, tdo_bit);
    check("instr", 32'(instruction), 32'(tap_pkg::IR_BYPASS));
    go_shift_dr();
    for (int i = 0; i < 4; i++) begin
      dbg.bit_cycle(i == 3, pat[i], seen4[i]);
    end
    check("bypass", 32'(seen4), 32'({pat[2:0], 1'b0}));
    dbg.bit_cycle(1'b1, 1'b0, tdo_bit);
    dbg.bit_cycle(1'b0, 1'b0, tdo_bit);
    dbg.set_reset(1'b0, 1'b1);
    #100;
    check("instr", 32'(instruction), 32'(tap_pkg::IR_RESET_VALUE));
    dbg.set_reset(1'b1, 1'b1);
    #200;
  endtask

  // ------------------------------------------------------------
  // clock and main sequence
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // reset, then every scenario in turn
  initial begin
    num_errors = 0;
    checks_done = 0;
    arst_n = 1'b0;
    single_wire_sel = 1'b0;
    single_wire_out = 1'b0;
    single_wire_oe = 1'b0;
    repeat (10) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    check("state", 32'(tap_state), 32'(tap_pkg::TEST_RESET));
    check("instr", 32'(instruction), 32'(tap_pkg::IR_RESET_VALUE));
    read_id();
    reset_async();
    bypass_ir();
    shared_pin();
    final_report();
  end
endmodule

`default_nettype wire
